// >>> core/lpcc_ctrl.sv
// Low-power clock control: clock source selection, CPU gating and standby modes.
// Assumes aclk is the PLL clock derived from the main oscillator, and that
// sub_osc_in is the free-running sub-oscillator from a pin (asynchronous).
// Clock outputs are enables for clock gates downstream of this block.
//
// Overview of operation
// - In PLL mode CPU and peripherals tick on every cycle of the PLL clock.
// - In main mode they tick at half the main oscillator rate and the PLL is off.
// - In sub mode they tick at a quarter of the sub-oscillator, main clock and PLL off.
// - With a CPU gap selected, peripherals keep full speed and the CPU ticks only on access.
// - Sleep in PLL mode stops only the CPU clock, the rest runs on the PLL clock.
// - Sleep in main mode stops only the CPU clock, the rest runs on the halved main clock.
// - Sleep in sub mode stops only the CPU clock, the rest runs on the quartered sub clock.
// - Timebase mode keeps oscillation, timebase and watch timers and stops all else.
// - Watch mode runs only the watch timer with sub-oscillator on, main and PLL off.
// - Stop mode halts oscillation and all functions while state is retained.
// - The clock select register holds status, wait, request and multiplier fields, resets to FC.
// - The mode control register holds stop, sleep, hold, reset, timebase and gap bits, resets to 18.
//
// Added by the designer: the AXI4-Lite register port.
module lpcc_ctrl
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sub_osc_in,
    input wire logic cpu_access,
    input wire logic wake_irq,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic timebase_clk_en,
    output logic watch_clk_en,
    output logic pll_on,
    output logic main_osc_on,
    output logic sub_osc_on,
    output logic pin_state_hold,
    output logic sw_reset_req,
    output lpcc_pkg::lpcc_src_t active_src,
    output lpcc_pkg::lpcc_pm_t power_mode
);
    import lpcc_pkg::*;

    // ****************************************
    // Declarations
    // ****************************************
    logic aw_have_r, w_have_r, bvalid_r, rvalid_r;
    logic [11:0] awaddr_r;
    logic [31:0] wdata_r, rdata_r;
    logic [3:0] wstrb_r;
    logic [1:0] bresp_r, rresp_r;
    logic wr_fire, lpm_wr, cks_wr;
    logic [7:0] lpm_rd, cks_rd;
    logic pin_state_hold_r, rsv_r;
    logic [1:0] gap_sel_r, wait_sel_r, mult_sel_r;
    logic sub_req_r, main_req_r;
    lpcc_src_t src_r, target_r, req_src;
    lpcc_pm_t pm_r;
    logic switching_r;
    logic [15:0] wait_cnt_r, wait_len;
    logic sub_s1_r, sub_s2_r, sub_s3_r, sub_edge, sub_tick;
    logic [1:0] sub_div_r;
    logic main_div_r, base_tick;
    logic [7:0] gap_cnt_r, gap_len;
    logic cpu_tick, cpu_nxt, periph_nxt, tb_nxt, watch_nxt;
    logic pll_nxt, main_nxt, sub_nxt;
    logic cpu_clk_en_r, periph_clk_en_r, tb_clk_en_r, watch_clk_en_r;
    logic pll_on_r, main_osc_on_r, sub_osc_on_r, sw_reset_r;
    logic stop_wr, sleep_wr, tb_wr, rst_wr;

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    assign s_axi_awready = !aw_have_r && !bvalid_r;
    assign s_axi_wready = !w_have_r && !bvalid_r;
    assign wr_fire = aw_have_r && w_have_r && !bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            awaddr_r <= 12'h000;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            else if (wr_fire)
                aw_have_r <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            else if (wr_fire)
                w_have_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_r <= 1'b0;
            bresp_r <= `LPCC_RESP_OK;
        end
        else if (wr_fire)
        begin
            bvalid_r <= 1'b1;
            bresp_r <= (awaddr_r == `LPCC_LPM_ADDR || awaddr_r == `LPCC_CKS_ADDR)
                ? `LPCC_RESP_OK : `LPCC_RESP_ERR;
        end
        else if (s_axi_bready)
            bvalid_r <= 1'b0;
    end

    // Status flags follow the live source, not the request
    assign cks_rd = {src_r != lpcc_src_sub, src_r != lpcc_src_pll, wait_sel_r,
        sub_req_r, main_req_r, mult_sel_r};
    // Write-only bits read back at their idle values
    assign lpm_rd = {2'b00, pin_state_hold_r, 2'b11, gap_sel_r, rsv_r};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= `LPCC_RESP_OK;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_r <= 1'b1;
            rresp_r <= `LPCC_RESP_OK;
            if (s_axi_araddr == `LPCC_LPM_ADDR)
                rdata_r <= {24'h000000, lpm_rd};
            else if (s_axi_araddr == `LPCC_CKS_ADDR)
                rdata_r <= {24'h000000, cks_rd};
            else
            begin
                rdata_r <= 32'h0000_0000;
                rresp_r <= `LPCC_RESP_ERR;
            end
        end
        else if (s_axi_rready)
            rvalid_r <= 1'b0;
    end

    // ****************************************
    // Registers
    // ****************************************
    assign lpm_wr = wr_fire && wstrb_r[0] && awaddr_r == `LPCC_LPM_ADDR;
    assign cks_wr = wr_fire && wstrb_r[0] && awaddr_r == `LPCC_CKS_ADDR;
    // Reset and timebase requests are taken on a written zero
    assign stop_wr = lpm_wr && wdata_r[`LPCC_LPM_STOP];
    assign sleep_wr = lpm_wr && wdata_r[`LPCC_LPM_SLEEP];
    assign tb_wr = lpm_wr && !wdata_r[`LPCC_LPM_TMD];
    assign rst_wr = lpm_wr && !wdata_r[`LPCC_LPM_RESET];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_state_hold_r <= 1'(`LPCC_LPM_RST >> `LPCC_LPM_HOLD);
            gap_sel_r <= 2'(`LPCC_LPM_RST >> `LPCC_LPM_GAP_LO);
            rsv_r <= 1'(`LPCC_LPM_RST);
        end
        else if (lpm_wr)
        begin
            pin_state_hold_r <= wdata_r[`LPCC_LPM_HOLD];
            gap_sel_r <= wdata_r[`LPCC_LPM_GAP_HI:`LPCC_LPM_GAP_LO];
            rsv_r <= wdata_r[`LPCC_LPM_RSV];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wait_sel_r <= 2'(`LPCC_CKS_RST >> `LPCC_CKS_WS_LO);
            sub_req_r <= 1'(`LPCC_CKS_RST >> `LPCC_CKS_SCS);
            main_req_r <= 1'(`LPCC_CKS_RST >> `LPCC_CKS_MCS);
            mult_sel_r <= 2'(`LPCC_CKS_RST);
        end
        else if (cks_wr)
        begin
            wait_sel_r <= wdata_r[`LPCC_CKS_WS_HI:`LPCC_CKS_WS_LO];
            sub_req_r <= wdata_r[`LPCC_CKS_SCS];
            main_req_r <= wdata_r[`LPCC_CKS_MCS];
            mult_sel_r <= wdata_r[`LPCC_CKS_CS_HI:`LPCC_CKS_CS_LO];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            sw_reset_r <= 1'b0;
        else
            sw_reset_r <= rst_wr;
    end

    // ****************************************
    // Clock sources
    // ****************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sub_s1_r <= 1'b0;
            sub_s2_r <= 1'b0;
            sub_s3_r <= 1'b0;
        end
        else
        begin
            sub_s1_r <= sub_osc_in;
            sub_s2_r <= sub_s1_r;
            sub_s3_r <= sub_s2_r;
        end
    end
    assign sub_edge = sub_s2_r && !sub_s3_r;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            sub_div_r <= 2'h0;
        else if (sub_edge)
            sub_div_r <= sub_div_r + 2'h1;
    end
    assign sub_tick = sub_edge && sub_div_r == 2'h3;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            main_div_r <= 1'b0;
        else if (main_osc_on_r)
            main_div_r <= !main_div_r;
        else
            main_div_r <= 1'b0;
    end

    always_comb
    begin
        case (src_r)
            lpcc_src_pll: base_tick = 1'b1;
            lpcc_src_main: base_tick = main_div_r;
            lpcc_src_sub: base_tick = sub_tick;
            default: base_tick = 1'b0;
        endcase
    end

    // ****************************************
    // Source switching
    // ****************************************
    always_comb
    begin
        if (!sub_req_r)
            req_src = lpcc_src_sub;
        else if (main_req_r)
            req_src = lpcc_src_main;
        else
            req_src = lpcc_src_pll;
        case (wait_sel_r)
            2'h0: wait_len = `LPCC_WAIT_0;
            2'h1: wait_len = `LPCC_WAIT_1;
            2'h2: wait_len = `LPCC_WAIT_2;
            default: wait_len = `LPCC_WAIT_3;
        endcase
    end

    // New source is only adopted after its oscillation wait ends
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            src_r <= lpcc_src_main;
            target_r <= lpcc_src_main;
            switching_r <= 1'b0;
        end
        else if (!switching_r && pm_r == lpcc_pm_run && req_src != src_r)
        begin
            target_r <= req_src;
            switching_r <= 1'b1;
        end
        else if (switching_r && wait_cnt_r == 16'h0000)
        begin
            src_r <= target_r;
            switching_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            wait_cnt_r <= 16'h0000;
        else if ((!switching_r && pm_r == lpcc_pm_run && req_src != src_r)
            || (pm_r == lpcc_pm_stop && wake_irq))
            wait_cnt_r <= wait_len;
        else if (wait_cnt_r != 16'h0000)
            wait_cnt_r <= wait_cnt_r - 16'h0001;
    end

    // ****************************************
    // Standby modes
    // ****************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            pm_r <= lpcc_pm_run;
        else
        begin
            case (pm_r)
                lpcc_pm_run:
                    if (stop_wr)
                        pm_r <= lpcc_pm_stop;
                    else if (sleep_wr)
                        pm_r <= lpcc_pm_sleep;
                    else if (tb_wr)
                        pm_r <= (src_r == lpcc_src_sub) ? lpcc_pm_watch : lpcc_pm_timebase;
                lpcc_pm_sleep, lpcc_pm_timebase, lpcc_pm_watch:
                    if (wake_irq)
                        pm_r <= lpcc_pm_run;
                lpcc_pm_stop:
                    if (wake_irq)
                        pm_r <= lpcc_pm_osc_wait;
                lpcc_pm_osc_wait:
                    if (wait_cnt_r == 16'h0000)
                        pm_r <= lpcc_pm_run;
                default: pm_r <= lpcc_pm_run;
            endcase
        end
    end

    // ****************************************
    // CPU intermittent gating
    // ****************************************
    always_comb
    begin
        case (gap_sel_r)
            2'h1: gap_len = `LPCC_GAP_1;
            2'h2: gap_len = `LPCC_GAP_2;
            2'h3: gap_len = `LPCC_GAP_3;
            default: gap_len = 8'h00;
        endcase
    end

    assign cpu_tick = base_tick && pm_r == lpcc_pm_run && !switching_r;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            gap_cnt_r <= 8'h00;
        else if (cpu_nxt && gap_sel_r != 2'h0)
            gap_cnt_r <= gap_len;
        else if (base_tick && gap_cnt_r != 8'h00)
            gap_cnt_r <= gap_cnt_r - 8'h01;
    end

    // ****************************************
    // Gate enables
    // ****************************************
    always_comb
    begin
        if (gap_sel_r == 2'h0)
            cpu_nxt = cpu_tick;
        else
            cpu_nxt = cpu_tick && cpu_access && gap_cnt_r == 8'h00;
        // Sleep drops only the CPU; peripherals stay on the base clock
        periph_nxt = base_tick && (pm_r == lpcc_pm_run || pm_r == lpcc_pm_sleep);
        main_nxt = (pm_r == lpcc_pm_run || pm_r == lpcc_pm_sleep || pm_r == lpcc_pm_timebase)
            && (src_r != lpcc_src_sub || (switching_r && target_r != lpcc_src_sub));
        pll_nxt = (pm_r == lpcc_pm_run || pm_r == lpcc_pm_sleep)
            && (src_r == lpcc_src_pll || (switching_r && target_r == lpcc_src_pll));
        sub_nxt = pm_r != lpcc_pm_stop && pm_r != lpcc_pm_osc_wait;
        tb_nxt = main_div_r && main_osc_on_r && pm_r != lpcc_pm_stop;
        watch_nxt = sub_edge && sub_nxt;
    end

    // Registered enables keep glitches away from the clock gates
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cpu_clk_en_r <= 1'b0;
            periph_clk_en_r <= 1'b0;
            tb_clk_en_r <= 1'b0;
            watch_clk_en_r <= 1'b0;
            pll_on_r <= 1'b0;
            main_osc_on_r <= 1'b1;
            sub_osc_on_r <= 1'b1;
        end
        else
        begin
            cpu_clk_en_r <= cpu_nxt;
            periph_clk_en_r <= periph_nxt;
            tb_clk_en_r <= tb_nxt;
            watch_clk_en_r <= watch_nxt;
            pll_on_r <= pll_nxt;
            main_osc_on_r <= main_nxt;
            sub_osc_on_r <= sub_nxt;
        end
    end

    assign cpu_clk_en = cpu_clk_en_r;
    assign periph_clk_en = periph_clk_en_r;
    assign timebase_clk_en = tb_clk_en_r;
    assign watch_clk_en = watch_clk_en_r;
    assign pll_on = pll_on_r;
    assign main_osc_on = main_osc_on_r;
    assign sub_osc_on = sub_osc_on_r;
    assign pin_state_hold = pin_state_hold_r;
    assign sw_reset_req = sw_reset_r;
    assign active_src = src_r;
    assign power_mode = pm_r;

endmodule : lpcc_ctrl

// >>> core/lpcc_defs.svh
// Constants of the low-power clock control block: register indices,
// field positions, reset values and wait counts.
// Assumes inclusion by bare name from the package and the testbench.
`ifndef LPCC_DEFS_SVH
`define LPCC_DEFS_SVH
// ****************************************
// Register map (index, byte address = 4 * index)
// ****************************************
`define LPCC_LPM_IDX 8'hA0
`define LPCC_CKS_IDX 8'hA1
`define LPCC_LPM_ADDR {2'h0, `LPCC_LPM_IDX, 2'h0}
`define LPCC_CKS_ADDR {2'h0, `LPCC_CKS_IDX, 2'h0}
`define LPCC_LPM_RST 8'h18
`define LPCC_CKS_RST 8'hFC
// ****************************************
// Field positions
// ****************************************
`define LPCC_LPM_STOP 7
`define LPCC_LPM_SLEEP 6
`define LPCC_LPM_HOLD 5
`define LPCC_LPM_RESET 4
`define LPCC_LPM_TMD 3
`define LPCC_LPM_GAP_HI 2
`define LPCC_LPM_GAP_LO 1
`define LPCC_LPM_RSV 0
`define LPCC_CKS_SCM 7
`define LPCC_CKS_MCM 6
`define LPCC_CKS_WS_HI 5
`define LPCC_CKS_WS_LO 4
`define LPCC_CKS_SCS 3
`define LPCC_CKS_MCS 2
`define LPCC_CKS_CS_HI 1
`define LPCC_CKS_CS_LO 0
// ****************************************
// Oscillation wait and CPU gap counts (cycles)
// ****************************************
`define LPCC_WAIT_0 16'h0010
`define LPCC_WAIT_1 16'h0040
`define LPCC_WAIT_2 16'h0100
`define LPCC_WAIT_3 16'h0400
`define LPCC_GAP_1 8'h08
`define LPCC_GAP_2 8'h10
`define LPCC_GAP_3 8'h20
`define LPCC_RESP_OK 2'h0
`define LPCC_RESP_ERR 2'h2
`endif

// >>> core/lpcc_pkg.sv
// Types of the low-power clock control block.
// Assumes lpcc_defs.svh sits in the include path.
package lpcc_pkg;
`include "lpcc_defs.svh"
    typedef enum logic [1:0] {lpcc_src_pll, lpcc_src_main, lpcc_src_sub} lpcc_src_t;
    typedef enum logic [2:0] {
        lpcc_pm_run,
        lpcc_pm_sleep,
        lpcc_pm_timebase,
        lpcc_pm_watch,
        lpcc_pm_stop,
        lpcc_pm_osc_wait
    } lpcc_pm_t;
endpackage : lpcc_pkg

// >>> testbench/lpcc_ctrl_sva.sv
// Concurrent checks on the ports of the low-power clock control block.
// Assumes binding to lpcc_ctrl, one clock aclk and sync reset aresetn.
module lpcc_ctrl_sva
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic cpu_clk_en,
    input wire logic periph_clk_en,
    input wire logic timebase_clk_en,
    input wire logic watch_clk_en,
    input wire logic pll_on,
    input wire logic main_osc_on,
    input wire logic sub_osc_on,
    input wire logic sw_reset_req,
    input wire lpcc_pkg::lpcc_src_t active_src,
    input wire lpcc_pkg::lpcc_pm_t power_mode
);
    import lpcc_pkg::*;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ****************************************
    // Properties
    // ****************************************
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write response missing");
    a_reset_pulse: assert property (
        sw_reset_req |=> !sw_reset_req)
        else $error("software reset pulse too long");
    a_sleep_cpu_off: assert property (
        (power_mode == lpcc_pm_sleep)[*2] |-> !cpu_clk_en)
        else $error("cpu tick during sleep");
    a_pll_sleep_run: assert property (
        (power_mode == lpcc_pm_sleep && active_src == lpcc_src_pll)[*2] |-> periph_clk_en)
        else $error("peripheral tick lost in pll sleep");
    a_main_half_rate: assert property (
        active_src == lpcc_src_main && periph_clk_en |=>
        !periph_clk_en || active_src != lpcc_src_main)
        else $error("main mode ticks faster than half rate");
    a_timebase_halt: assert property (
        (power_mode == lpcc_pm_timebase)[*2] |-> !cpu_clk_en && !periph_clk_en)
        else $error("cpu or peripheral tick in timebase mode");
    a_watch_only: assert property (
        (power_mode == lpcc_pm_watch)[*3] |-> !periph_clk_en && !timebase_clk_en
        && !main_osc_on && !pll_on && sub_osc_on)
        else $error("watch mode runs more than the watch timer");
    a_stop_dead: assert property (
        (power_mode == lpcc_pm_stop)[*3] |-> !cpu_clk_en && !periph_clk_en
        && !watch_clk_en && !main_osc_on && !sub_osc_on)
        else $error("activity during stop");
endmodule : lpcc_ctrl_sva

bind lpcc_ctrl lpcc_ctrl_sva u_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .cpu_clk_en, .periph_clk_en,
    .timebase_clk_en, .watch_clk_en, .pll_on, .main_osc_on, .sub_osc_on, .sw_reset_req,
    .active_src, .power_mode);

// >>> testbench/testbench.sv
// Self-checking bench for the low-power clock control block.
// Assumes lpcc_pkg and lpcc_defs.svh are compiled and on the include path.
`include "lpcc_defs.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import lpcc_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000;
    logic [11:0] s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b1;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b1;
    logic sub_osc_in = 1'b0;
    logic cpu_access = 1'b0;
    logic wake_irq = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic cpu_clk_en, periph_clk_en, timebase_clk_en, watch_clk_en, pll_on;
    logic main_osc_on, sub_osc_on, pin_state_hold, sw_reset_req;
    lpcc_src_t active_src;
    lpcc_pm_t power_mode;
    int errors = 0;
    int tests_run = 0;
    int cycles = 0;
    int sub_div = 0;
    int rst_seen = 0;

    lpcc_ctrl u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sub_osc_in,
        .cpu_access, .wake_irq, .cpu_clk_en, .periph_clk_en, .timebase_clk_en,
        .watch_clk_en, .pll_on, .main_osc_on, .sub_osc_on, .pin_state_hold,
        .sw_reset_req, .active_src, .power_mode);

    always #5 aclk = ~aclk;

    // Free-running sub oscillator, six aclk periods per cycle
    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        sub_div <= (sub_div == 2) ? 0 : sub_div + 1;
        if (sub_div == 2)
            sub_osc_in <= ~sub_osc_in;
        if (sw_reset_req === 1'b1)
            rst_seen <= rst_seen + 1;
    end

    always @(posedge aclk)
    begin
        if (cycles == 20000)
        begin
            errors++;
            complete_run();
        end
    end

    task complete_run;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : complete_run

    task chk_val(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_val

    task chk_range(input int got, input int lo, input int hi);
        tests_run++;
        if (got < lo || got > hi)
        begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask : chk_range

    // ****************************************
    // Bus and measurement helpers
    // ****************************************
    task axi(input logic wr, input logic [11:0] a, input logic [7:0] d,
        output logic [31:0] rd, output logic [1:0] resp);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= wr;
        s_axi_wvalid <= wr;
        s_axi_arvalid <= !wr;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!(wr ? s_axi_bvalid : s_axi_rvalid));
        rd = s_axi_rdata;
        resp = wr ? s_axi_bresp : s_axi_rresp;
        chk_range(n, 1, 99);
    endtask : axi

    task wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] rd;
        logic [1:0] resp;
        axi(1'b1, a, d, rd, resp);
        chk_val(resp, `LPCC_RESP_OK);
    endtask : wr

    task rd_chk(input logic [11:0] a, input logic [7:0] exp);
        logic [31:0] rd;
        logic [1:0] resp;
        axi(1'b0, a, 8'h00, rd, resp);
        chk_val(resp, `LPCC_RESP_OK);
        chk_val(rd, {24'h000000, exp});
    endtask : rd_chk

    task count_ticks(input int n, output int c, output int p, output int t, output int w);
        c = 0;
        p = 0;
        t = 0;
        w = 0;
        repeat (n)
        begin
            @(posedge aclk);
            c += (cpu_clk_en === 1'b1);
            p += (periph_clk_en === 1'b1);
            t += (timebase_clk_en === 1'b1);
            w += (watch_clk_en === 1'b1);
        end
    endtask : count_ticks

    task wait_src(input lpcc_src_t s, output int n);
        n = 0;
        while (active_src !== s && n < 200)
        begin
            @(posedge aclk);
            n++;
        end
    endtask : wait_src

    // Enter a standby mode, measure 48 cycles of ticks, then wake it
    task standby(input logic [7:0] lpm, input lpcc_pm_t pm, input int p_lo, input int p_hi,
        input int t_lo, input int t_hi, input int w_lo, input int w_hi, input logic osc);
        int c, p, t, w, n;
        wr(`LPCC_LPM_ADDR, lpm);
        repeat (4) @(posedge aclk);
        chk_val(power_mode, pm);
        chk_val(main_osc_on, osc);
        count_ticks(48, c, p, t, w);
        chk_range(c, 0, 0);
        chk_range(p, p_lo, p_hi);
        chk_range(t, t_lo, t_hi);
        chk_range(w, w_lo, w_hi);
        wake_irq <= 1'b1;
        n = 0;
        while (power_mode !== lpcc_pm_run && n < 200)
        begin
            @(posedge aclk);
            n++;
        end
        wake_irq <= 1'b0;
        chk_range(n, 1, 199);
        $display("test standby %0d done", pm);
    endtask : standby

    // ****************************************
    // Scenarios
    // ****************************************
    task t_reset;
        int c, p, t, w;
        logic [31:0] d;
        logic [1:0] r;
        rd_chk(`LPCC_LPM_ADDR, 8'h18);
        rd_chk(`LPCC_CKS_ADDR, 8'hFC);
        chk_val({main_osc_on, pll_on, active_src}, {2'b10, lpcc_src_main});
        count_ticks(20, c, p, t, w);
        chk_range(p, 10, 10);
        chk_range(c, 10, 10);
        wr(`LPCC_CKS_ADDR, 8'h3C);
        rd_chk(`LPCC_CKS_ADDR, 8'hFC);
        wr(`LPCC_LPM_ADDR, 8'h38);
        rd_chk(`LPCC_LPM_ADDR, 8'h38);
        chk_val(pin_state_hold, 1'b1);
        wr(`LPCC_LPM_ADDR, 8'h08);
        repeat (3) @(posedge aclk);
        chk_range(rst_seen, 1, 1);
        rd_chk(`LPCC_LPM_ADDR, 8'h18);
        // Unmapped place answers with an error and reads zero
        axi(1'b1, 12'h300, 8'hFF, d, r);
        chk_val(r, `LPCC_RESP_ERR);
        axi(1'b0, 12'h300, 8'h00, d, r);
        chk_val(r, `LPCC_RESP_ERR);
        chk_val(d, 32'h0000_0000);
        $display("test reset done");
    endtask : t_reset

    task t_pll;
        int c, p, t, w, n;
        wr(`LPCC_CKS_ADDR, 8'h08);
        rd_chk(`LPCC_CKS_ADDR, 8'hC8);
        wait_src(lpcc_src_pll, n);
        chk_range(n, 8, 40);
        rd_chk(`LPCC_CKS_ADDR, 8'h88);
        chk_val(pll_on, 1'b1);
        count_ticks(20, c, p, t, w);
        chk_range(p + c, 40, 40);
        standby(8'h58, lpcc_pm_sleep, 48, 48, 23, 25, 7, 9, 1'b1);
        // Intermittent CPU: ticks only on access, peripherals at full rate
        wr(`LPCC_LPM_ADDR, 8'h1A);
        count_ticks(40, c, p, t, w);
        chk_range(c, 0, 0);
        chk_range(p, 40, 40);
        cpu_access <= 1'b1;
        count_ticks(45, c, p, t, w);
        chk_range(c, 4, 6);
        chk_range(p, 45, 45);
        cpu_access <= 1'b0;
        wr(`LPCC_LPM_ADDR, 8'h18);
        standby(8'h10, lpcc_pm_timebase, 0, 0, 23, 25, 7, 9, 1'b1);
        wr(`LPCC_LPM_ADDR, 8'h38);
        standby(8'hB8, lpcc_pm_stop, 0, 0, 0, 0, 0, 0, 1'b0);
        rd_chk(`LPCC_LPM_ADDR, 8'h38);
        chk_val(active_src, lpcc_src_pll);
        wr(`LPCC_LPM_ADDR, 8'h18);
        $display("test pll done");
    endtask : t_pll

    task t_sub;
        int c, p, t, w, n;
        wr(`LPCC_CKS_ADDR, 8'h00);
        wait_src(lpcc_src_sub, n);
        chk_range(n, 8, 199);
        repeat (4) @(posedge aclk);
        rd_chk(`LPCC_CKS_ADDR, 8'h40);
        chk_val({main_osc_on, pll_on}, 2'b00);
        count_ticks(96, c, p, t, w);
        chk_range(p, 3, 5);
        standby(8'h58, lpcc_pm_sleep, 1, 3, 0, 0, 7, 9, 1'b0);
        standby(8'h10, lpcc_pm_watch, 0, 0, 0, 0, 7, 9, 1'b0);
        $display("test sub done");
    endtask : t_sub

    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        standby(8'h58, lpcc_pm_sleep, 23, 25, 23, 25, 7, 9, 1'b1);
        t_pll();
        t_sub();
        complete_run();
    end
endmodule : testbench
